/* sic_ctrl.v */
// interrupt and standby control register with serial access and wake sampling
`timescale 1ns/1ns
`default_nettype none
`include "sic_map.vh"
// What this block does
// (R1) lock bit set makes register read only
// (R2) main supply warning irq only when enabled
// (R3) can supply warning irq only when enabled
// (R4) lin a normal, standby clear: active, flag cleared
// (R5) lin a low mode, standby clear: off, no wake
// (R6) lin a standby set: low power, wake on
// (R7) lin b normal, standby clear: active, flag cleared
// (R8) lin b low mode, standby clear: off, no wake
// (R9) lin b standby set: low power, wake on
// (R10) wake a edge select: off, rise, fall, both
// (R11) wake b edge select: off, rise, fall, both
// (R12) can normal, standby clear: active, flag cleared
// (R13) can low mode, standby clear: off, no wake
// (R14) can standby set: low power, wake on
// (R15) reset level select: 0 high, 1 low
// (R16) wake a sampling continuous or bias synchronised
// (R17) wake b sampling continuous or bias synchronised
// (R18) chip mode upper bit set means normal
// (R19) bias rate bit picks 16 or 64 ms
module sic_ctrl #(
  parameter integer PERIOD_SHORT_CYC = `SIC_PERIOD_SHORT_CYC,
  parameter integer PERIOD_LONG_CYC = `SIC_PERIOD_LONG_CYC,
  parameter integer BIAS_ON_CYC = `SIC_BIAS_ON_CYC,
  parameter integer CNT_W = 23
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  // serial port, sampled as synchronous inputs
  input wire spi_sck_in,
  input wire spi_cs_n_in,
  input wire spi_mosi_in,
  output reg spi_miso_out,
  output wire spi_miso_oe_out,
  // chip mode from the mode control register
  input wire [1:0] chip_mode_field_in,
  // bias rate bit, kept in the mode control register
  input wire bias_sample_rate_ctrl_in,
  // regulator warnings
  input wire main_uv_warn_in,
  input wire can_uv_warn_in,
  output reg main_uv_irq_out,
  output reg can_uv_irq_out,
  // transceiver control
  input wire lin_a_bus_wake_in,
  input wire lin_b_bus_wake_in,
  input wire can_bus_wake_in,
  output reg [1:0] lin_a_mode_out,
  output reg [1:0] lin_b_mode_out,
  output reg [1:0] can_mode_out,
  output reg lin_a_wake_det_en_out,
  output reg lin_b_wake_det_en_out,
  output reg can_wake_det_en_out,
  output reg lin_a_flag_clr_out,
  output reg lin_b_flag_clr_out,
  output reg can_flag_clr_out,
  output reg lin_a_wake_irq_out,
  output reg lin_b_wake_irq_out,
  output reg can_wake_irq_out,
  // regulator reset threshold
  output reg reset_level_select_out,
  // local wake inputs and bias pin
  input wire wake_input_a_in,
  input wire wake_input_b_in,
  output reg wake_a_irq_out,
  output reg wake_b_irq_out,
  output reg wake_bias_output_out,
  output reg wake_bias_output_oe_out,
  // register contents, for observation
  output wire [15:0] ctrl_reg_out
);

  ////////////////////////////////////////////////////////////////////////
  // decoding shared by the three transceivers and the two wake inputs

  function [1:0] trx_mode;
    input stb;
    input [1:0] mc;
    begin
      if (stb)
        trx_mode = `SIC_TRX_LOWPWR;
      else if (mc[1])
        trx_mode = `SIC_TRX_ACTIVE;
      else
        trx_mode = `SIC_TRX_OFF;
    end
  endfunction

  function edge_hit;
    input [1:0] sel;
    input old_v;
    input new_v;
    begin
      case (sel)
        `SIC_EDGE_RISE: edge_hit = ~old_v & new_v;
        `SIC_EDGE_FALL: edge_hit = old_v & ~new_v;
        `SIC_EDGE_BOTH: edge_hit = old_v ^ new_v;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial frame: 16 bits msb first, sampled on sck rise, shifted on fall

  reg [15:0] ctrl_q;
  reg [15:0] ctrl_d;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [4:0] bit_cnt_q;
  reg sck_q;
  reg cs_n_q;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire frame_ok;
  wire locked;

  assign sck_rise = spi_sck_in & ~sck_q;
  assign sck_fall = ~spi_sck_in & sck_q;
  assign cs_fall = ~spi_cs_n_in & cs_n_q;
  assign cs_rise = spi_cs_n_in & ~cs_n_q;
  assign frame_ok = (bit_cnt_q == 5'h10) &&
                    (rx_q[`SIC_ADDR_HI:`SIC_ADDR_LO] == `SIC_OWN_ADDR);
  assign locked = ctrl_q[`SIC_LOCK_BIT];
  assign ctrl_reg_out = ctrl_q;
  assign spi_miso_oe_out = ~spi_cs_n_in;

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      spi_miso_out <= 1'b0;
    end
    else
    begin
      sck_q <= spi_sck_in;
      cs_n_q <= spi_cs_n_in;
      if (cs_fall)
      begin
        // snapshot so the read-back is stable across the frame
        tx_q <= {ctrl_q[14:0], 1'b0};
        spi_miso_out <= ctrl_q[15];
        bit_cnt_q <= 5'h00;
      end
      else if (!spi_cs_n_in)
      begin
        if (sck_rise)
        begin
          rx_q <= {rx_q[14:0], spi_mosi_in};
          if (bit_cnt_q != 5'h1f)
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (sck_fall)
        begin
          spi_miso_out <= tx_q[15];
          tx_q <= {tx_q[14:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register update at frame end

  always @*
  begin
    ctrl_d = ctrl_q;
    // (R1) writes only while unlocked
    if (cs_rise && frame_ok && !locked)
      ctrl_d = (ctrl_q & ~`SIC_WR_MASK) | (rx_q & `SIC_WR_MASK);
  end

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctrl_q <= `SIC_RESET_VAL;
    else
      ctrl_q <= ctrl_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // regulator warnings and reset level

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      main_uv_irq_out <= 1'b0;
      can_uv_irq_out <= 1'b0;
      reset_level_select_out <= 1'b0;
    end
    else
    begin
      // (R2) main warning gated by enable
      main_uv_irq_out <= main_uv_warn_in & ctrl_q[`SIC_MAIN_UVIE_BIT];
      // (R3) can warning gated by enable
      can_uv_irq_out <= can_uv_warn_in & ctrl_q[`SIC_CAN_UVIE_BIT];
      // (R15) threshold select passed out
      reset_level_select_out <= ctrl_q[`SIC_RST_LVL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transceiver standby control

  wire stb_lin_a;
  wire stb_lin_b;
  wire stb_can;
  wire normal_mode;

  assign stb_lin_a = ctrl_q[`SIC_LIN_A_STB_BIT];
  assign stb_lin_b = ctrl_q[`SIC_LIN_B_STB_BIT];
  assign stb_can = ctrl_q[`SIC_CAN_STB_BIT];
  // (R18) upper mode bit marks normal
  assign normal_mode = chip_mode_field_in[1];

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lin_a_mode_out <= `SIC_TRX_OFF;
      lin_b_mode_out <= `SIC_TRX_OFF;
      can_mode_out <= `SIC_TRX_OFF;
      lin_a_wake_det_en_out <= 1'b0;
      lin_b_wake_det_en_out <= 1'b0;
      can_wake_det_en_out <= 1'b0;
      lin_a_flag_clr_out <= 1'b0;
      lin_b_flag_clr_out <= 1'b0;
      can_flag_clr_out <= 1'b0;
      lin_a_wake_irq_out <= 1'b0;
      lin_b_wake_irq_out <= 1'b0;
      can_wake_irq_out <= 1'b0;
    end
    else
    begin
      // (R4) active in normal, flag held clear
      lin_a_mode_out <= trx_mode(stb_lin_a, chip_mode_field_in);
      lin_a_flag_clr_out <= ~stb_lin_a & normal_mode;
      // (R5) off in low modes, no wake
      // (R6) low power keeps wake detection
      lin_a_wake_det_en_out <= stb_lin_a;
      lin_a_wake_irq_out <= stb_lin_a & lin_a_bus_wake_in;
      // (R7) active in normal, flag held clear
      lin_b_mode_out <= trx_mode(stb_lin_b, chip_mode_field_in);
      lin_b_flag_clr_out <= ~stb_lin_b & normal_mode;
      // (R8) off in low modes, no wake
      // (R9) low power keeps wake detection
      lin_b_wake_det_en_out <= stb_lin_b;
      lin_b_wake_irq_out <= stb_lin_b & lin_b_bus_wake_in;
      // (R12) active in normal, flag held clear
      can_mode_out <= trx_mode(stb_can, chip_mode_field_in);
      can_flag_clr_out <= ~stb_can & normal_mode;
      // (R13) off in low modes, no wake
      // (R14) low power keeps wake detection
      can_wake_det_en_out <= stb_can;
      can_wake_irq_out <= stb_can & can_bus_wake_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bias timing: period counter, bias pulse ends in the sample strobe

  reg [CNT_W-1:0] per_cnt_q;
  wire [CNT_W-1:0] per_last;
  wire any_sync;
  wire sample_stb;
  wire bias_win;
  wire rate_long;

  assign any_sync = ctrl_q[`SIC_WAKE_A_SYNC_BIT] | ctrl_q[`SIC_WAKE_B_SYNC_BIT];
  // rate bit lives outside this register; bit 5 here is wake b select
  assign rate_long = bias_sample_rate_ctrl_in;
  // (R19) rate bit picks the period
  assign per_last = rate_long ? PERIOD_LONG_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}
                              : PERIOD_SHORT_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
  assign sample_stb = any_sync && (per_cnt_q >= per_last);
  // bias drawn only for a short window to save quiescent current
  assign bias_win = any_sync && (per_cnt_q >= per_last - BIAS_ON_CYC[CNT_W-1:0]);

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      per_cnt_q <= {CNT_W{1'b0}};
      wake_bias_output_out <= 1'b0;
      wake_bias_output_oe_out <= 1'b0;
    end
    else
    begin
      if (!any_sync || per_cnt_q >= per_last)
        per_cnt_q <= {CNT_W{1'b0}};
      else
        per_cnt_q <= per_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      // no sync: rate bit set drives low, clear leaves floating
      wake_bias_output_out <= bias_win;
      wake_bias_output_oe_out <= any_sync | rate_long;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local wake inputs

  wire [1:0] wake_in;
  wire [1:0] wake_sync;
  wire [3:0] wake_sel;
  wire [1:0] wake_hit;

  assign wake_in = {wake_input_b_in, wake_input_a_in};
  assign wake_sync = {ctrl_q[`SIC_WAKE_B_SYNC_BIT], ctrl_q[`SIC_WAKE_A_SYNC_BIT]};
  assign wake_sel = {ctrl_q[`SIC_WAKE_B_SEL_HI:`SIC_WAKE_B_SEL_LO],
                     ctrl_q[`SIC_WAKE_A_SEL_HI:`SIC_WAKE_A_SEL_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_wake
      wire take;
      reg smp_q;
      reg hit_q;
      // (R16) continuous or strobed sampling
      // (R17) same choice for the second input
      assign take = ~wake_sync[gi] | sample_stb;
      assign wake_hit[gi] = hit_q;
      always @(posedge ref_clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          smp_q <= 1'b0;
          hit_q <= 1'b0;
        end
        else
        begin
          if (take)
            smp_q <= wake_in[gi];
          // (R10) edge select decode
          // (R11) edge select decode
          hit_q <= take & edge_hit(wake_sel[2*gi+1:2*gi], smp_q, wake_in[gi]);
        end
      end
    end
  endgenerate

  always @*
  begin
    wake_a_irq_out = wake_hit[0];
    wake_b_irq_out = wake_hit[1];
  end

endmodule // sic_ctrl
`default_nettype wire

/* sic_ctrl_checker.sv */
// port checks for the control register
`timescale 1ns/1ns
`default_nettype none
module sic_ctrl_checker (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] chip_mode_field_in,
  input wire logic main_uv_warn_in,
  input wire logic can_uv_warn_in,
  input wire logic main_uv_irq_out,
  input wire logic can_uv_irq_out,
  input wire logic [1:0] lin_a_mode_out,
  input wire logic lin_a_wake_det_en_out,
  input wire logic lin_a_flag_clr_out,
  input wire logic can_wake_irq_out,
  input wire logic reset_level_select_out,
  input wire logic wake_a_irq_out,
  input wire logic [15:0] ctrl_reg_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // keeps $past from looking into reset
  logic run_q;
  always @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      run_q <= 1'b0;
    else
      run_q <= 1'b1;
  ////////////////////////////////////////
  a_lock_freezes:
    assert property (ctrl_reg_out[12] |=> $stable(ctrl_reg_out)) else $error("locked reg changed");
  a_addr_fixed:
    assert property (ctrl_reg_out[15:13] == 3'h2) else $error("address field changed");
  a_main_irq_gate:
    assert property (run_q |->
      main_uv_irq_out == ($past(main_uv_warn_in) && $past(ctrl_reg_out[11])))
    else $error("main warn irq wrong");
  a_can_irq_gate:
    assert property (run_q |->
      can_uv_irq_out == ($past(can_uv_warn_in) && $past(ctrl_reg_out[10])))
    else $error("can warn irq wrong");
  // three cycles cover up to two stages of latency
  a_lin_a_active:
    assert property ((run_q && !ctrl_reg_out[9] && chip_mode_field_in[1])[*3] |->
      lin_a_mode_out == 2'h1 && lin_a_flag_clr_out) else $error("lin a not active");
  a_lin_a_off:
    assert property ((run_q && !ctrl_reg_out[9] && !chip_mode_field_in[1])[*3] |->
      lin_a_mode_out == 2'h0 && !lin_a_wake_det_en_out) else $error("lin a not off");
  a_lin_a_lowpwr:
    assert property ((run_q && ctrl_reg_out[9])[*3] |->
      lin_a_mode_out == 2'h2 && lin_a_wake_det_en_out) else $error("lin a not low power");
  a_can_off_quiet:
    assert property ((run_q && !ctrl_reg_out[3] && !chip_mode_field_in[1])[*3] |->
      !can_wake_irq_out) else $error("can wake irq while off");
  a_rst_level:
    assert property ((run_q && $stable(ctrl_reg_out[2]))[*2] |->
      reset_level_select_out == ctrl_reg_out[2]) else $error("reset level wrong");
  a_wake_a_off:
    assert property ((run_q && ctrl_reg_out[7:6] == 2'h0)[*4] |-> !wake_a_irq_out)
    else $error("wake a irq while disabled");
endmodule // sic_ctrl_checker
bind sic_ctrl sic_ctrl_checker u_chk (.ref_clk_in, .rst_n_in, .chip_mode_field_in,
  .main_uv_warn_in, .can_uv_warn_in, .main_uv_irq_out, .can_uv_irq_out, .lin_a_mode_out,
  .lin_a_wake_det_en_out, .lin_a_flag_clr_out, .can_wake_irq_out, .reset_level_select_out,
  .wake_a_irq_out, .ctrl_reg_out);
`default_nettype wire

/* sic_host_model.sv */
// host serial master model for the control register
`timescale 1ns/1ns
`default_nettype none
module sic_host_model (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // each sck phase held two cycles so the sampler never misses an edge
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      mosi_out = w[15 - i];
      repeat (2) @(posedge clk_in);
      #1 r = {r[14:0], miso_in};
      sck_out = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 sck_out = 1'b0;
    end
    repeat (2) @(posedge clk_in);
    #1 cs_n_out = 1'b1;
    // released line flips so a stale bit never passes for data
    mosi_out = ~mosi_out;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
endmodule // sic_host_model
`default_nettype wire

/* sic_map.vh */
// register layout, reset values and timing constants of the control register
`ifndef SIC_MAP_VH
`define SIC_MAP_VH

// frame and register geometry
`define SIC_REG_W 16
`define SIC_ADDR_HI 15
`define SIC_ADDR_LO 13
`define SIC_OWN_ADDR 3'h2
`define SIC_WR_MASK 16'h1fff

// field positions
`define SIC_LOCK_BIT 12
`define SIC_MAIN_UVIE_BIT 11
`define SIC_CAN_UVIE_BIT 10
`define SIC_LIN_A_STB_BIT 9
`define SIC_LIN_B_STB_BIT 8
`define SIC_WAKE_A_SEL_HI 7
`define SIC_WAKE_A_SEL_LO 6
`define SIC_WAKE_B_SEL_HI 5
`define SIC_WAKE_B_SEL_LO 4
`define SIC_CAN_STB_BIT 3
`define SIC_RST_LVL_BIT 2
`define SIC_WAKE_A_SYNC_BIT 1
`define SIC_WAKE_B_SYNC_BIT 0

// power-on value: address field 010, all control bits clear
`define SIC_RESET_VAL 16'h4000

// edge select codes
`define SIC_EDGE_OFF 2'h0
`define SIC_EDGE_RISE 2'h1
`define SIC_EDGE_FALL 2'h2
`define SIC_EDGE_BOTH 2'h3

// transceiver mode codes driven out
`define SIC_TRX_OFF 2'h0
`define SIC_TRX_ACTIVE 2'h1
`define SIC_TRX_LOWPWR 2'h2

// timing, clock in kHz, periods in ms, bias window in ns
`define SIC_CLK_KHZ 100000
`define SIC_CLK_NS 10
`define SIC_PERIOD_SHORT_MS 16
`define SIC_PERIOD_LONG_MS 64
`define SIC_BIAS_ON_NS 1000
`define SIC_PERIOD_SHORT_CYC (`SIC_PERIOD_SHORT_MS * `SIC_CLK_KHZ)
`define SIC_PERIOD_LONG_CYC (`SIC_PERIOD_LONG_MS * `SIC_CLK_KHZ)
`define SIC_BIAS_ON_CYC ((`SIC_BIAS_ON_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)

`endif

/* test_sic_ctrl.sv */
// self-checking bench for the interrupt and standby control register
`timescale 1ns/1ns
`default_nettype none
module test_sic_ctrl;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic spi_sck_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out;
  logic [1:0] chip_mode_field_in = 2'h0;
  logic main_uv_warn_in = 1'b0, can_uv_warn_in = 1'b0, main_uv_irq_out, can_uv_irq_out;
  logic lin_a_bus_wake_in = 1'b0, lin_b_bus_wake_in = 1'b0, can_bus_wake_in = 1'b0;
  logic [1:0] lin_a_mode_out, lin_b_mode_out, can_mode_out;
  logic lin_a_wake_det_en_out, lin_b_wake_det_en_out, can_wake_det_en_out;
  logic lin_a_flag_clr_out, lin_b_flag_clr_out, can_flag_clr_out, reset_level_select_out;
  logic lin_a_wake_irq_out, lin_b_wake_irq_out, can_wake_irq_out, wake_bias_output_out;
  logic wake_input_a_in = 1'b0, wake_input_b_in = 1'b0, wake_a_irq_out, wake_b_irq_out;
  logic wake_bias_output_oe_out;
  logic bias_sample_rate_ctrl_in = 1'b0;
  logic [15:0] ctrl_reg_out, rd, fr, e;
  logic [1:0] md;
  logic [5:0] ex;
  logic [23:0] rows [7];
  int miscompares = 0, tests_run = 0, na, nb;
  wire [15:0] trx_obs = {lin_a_mode_out, lin_b_mode_out, can_mode_out, reset_level_select_out,
    lin_a_wake_det_en_out, lin_b_wake_det_en_out, can_wake_det_en_out, lin_a_wake_irq_out,
    lin_b_wake_irq_out, can_wake_irq_out, lin_a_flag_clr_out, lin_b_flag_clr_out,
    can_flag_clr_out};
  // short periods keep the synchronised sampling run brief
  sic_ctrl #(.PERIOD_SHORT_CYC(40), .PERIOD_LONG_CYC(100), .BIAS_ON_CYC(4)) u_dut (
    .ref_clk_in, .rst_n_in, .spi_sck_in, .spi_cs_n_in, .spi_mosi_in, .spi_miso_out,
    .spi_miso_oe_out, .chip_mode_field_in, .bias_sample_rate_ctrl_in, .main_uv_warn_in,
    .can_uv_warn_in, .main_uv_irq_out, .can_uv_irq_out, .lin_a_bus_wake_in, .lin_b_bus_wake_in,
    .can_bus_wake_in, .lin_a_mode_out, .lin_b_mode_out, .can_mode_out,
    .lin_a_wake_det_en_out, .lin_b_wake_det_en_out, .can_wake_det_en_out,
    .lin_a_flag_clr_out, .lin_b_flag_clr_out, .can_flag_clr_out, .lin_a_wake_irq_out,
    .lin_b_wake_irq_out, .can_wake_irq_out, .reset_level_select_out, .wake_input_a_in,
    .wake_input_b_in, .wake_a_irq_out, .wake_b_irq_out, .wake_bias_output_out,
    .wake_bias_output_oe_out, .ctrl_reg_out);
  sic_host_model u_host (.clk_in(ref_clk_in), .miso_in(spi_miso_out), .sck_out(spi_sck_in),
    .cs_n_out(spi_cs_n_in), .mosi_out(spi_mosi_in));
  always #5 ref_clk_in = ~ref_clk_in;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr(input logic [15:0] w, input int n);
    logic [15:0] r;
    u_host.xfer(w, n, r);
  endtask
  task automatic count_pulses(input int n);
    na = 0;
    nb = 0;
    repeat (n)
    begin
      tick(1);
      na += (wake_a_irq_out === 1'b1);
      nb += (wake_b_irq_out === 1'b1);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    // roughly ten times the expected run
    #300000;
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    rows = '{{16'h4000, 2'h2, 6'h15}, {16'h4000, 2'h0, 6'h00}, {16'h4000, 2'h1, 6'h00},
      {16'h430c, 2'h0, 6'h2a}, {16'h430c, 2'h3, 6'h2a}, {16'h4204, 2'h3, 6'h25},
      {16'h4108, 2'h1, 6'h0a}};
    tick(4);
    rst_n_in = 1'b1;
    check(ctrl_reg_out, 16'h4000, "reset value");
    check(spi_miso_oe_out, 1'b0, "miso idle");
    fork
      u_host.xfer(16'h0000, 16, rd);
      begin
        tick(3);
        check(spi_miso_oe_out, 1'b1, "miso in frame");
      end
    join
    check({rd, ctrl_reg_out}, {2{16'h4000}}, "readback");
    $display("test reset done");
    {lin_a_bus_wake_in, lin_b_bus_wake_in, can_bus_wake_in} = 3'h7;
    foreach (rows[i])
    begin
      {fr, md, ex} = rows[i];
      chip_mode_field_in = md;
      wr(fr, 16);
      tick(2);
      e = {ex, fr[2], {2{fr[9], fr[8], fr[3]}}, ~{fr[9], fr[8], fr[3]} & {3{md[1]}}};
      check(ctrl_reg_out, fr, "ctrl");
      check(trx_obs, e, "trx");
    end
    {lin_a_bus_wake_in, lin_b_bus_wake_in, can_bus_wake_in} = 3'h0;
    $display("test rows done");
    for (int en = 0; en < 2; en++)
    begin
      wr(en ? 16'h4c00 : 16'h4000, 16);
      {main_uv_warn_in, can_uv_warn_in} = 2'h3;
      tick(2);
      check({main_uv_irq_out, can_uv_irq_out}, {2{en[0]}}, "uv irq");
      {main_uv_warn_in, can_uv_warn_in} = 2'h0;
      tick(2);
      check({main_uv_irq_out, can_uv_irq_out}, 2'h0, "uv irq idle");
    end
    $display("test uv done");
    for (int s = 0; s < 4; s++)
    begin
      wr({8'h40, s[1:0], s[1:0], 4'h0}, 16);
      {wake_input_a_in, wake_input_b_in} = 2'h3;
      count_pulses(8);
      check({na[15:0], nb[15:0]}, {2{15'h0000, s[0]}}, "rise pulses");
      {wake_input_a_in, wake_input_b_in} = 2'h0;
      count_pulses(8);
      check({na[15:0], nb[15:0]}, {2{15'h0000, s[1]}}, "fall pulses");
    end
    $display("test edges done");
    wr(16'h4003, 16);
    // bench periods 40 and 100, window 5: 200 cycles hold 25 or 10
    for (int w = 0; w < 2; w++)
    begin
      bias_sample_rate_ctrl_in = w[0];
      tick(110);
      na = 0;
      repeat (200)
      begin
        tick(1);
        na += (wake_bias_output_out === 1'b1);
      end
      check(na, w ? 10 : 25, "bias high cycles");
    end
    wr(16'h4000, 16);
    check({wake_bias_output_oe_out, wake_bias_output_out}, 2'h2, "bias held low");
    bias_sample_rate_ctrl_in = 1'b0;
    tick(2);
    check(wake_bias_output_oe_out, 1'b0, "bias floating");
    $display("test bias done");
    wr(16'h4043, 16);
    tick(1);
    check(wake_bias_output_oe_out, 1'b1, "bias enable");
    wake_input_a_in = 1'b1;
    count_pulses(4);
    check(na, 0, "no pulse before strobe");
    count_pulses(50);
    check(na, 1, "synced pulse");
    $display("test sync done");
    wr(16'h4fff, 15);
    check(ctrl_reg_out, 16'h4043, "short frame");
    wr(16'h6fff, 16);
    check(ctrl_reg_out, 16'h4043, "wrong address");
    wr(16'h5000, 16);
    wr(16'h4fff, 16);
    u_host.xfer(16'h0000, 16, rd);
    check({rd, ctrl_reg_out}, {2{16'h5000}}, "locked");
    rst_n_in = 1'b0;
    tick(2);
    rst_n_in = 1'b1;
    tick(1);
    check(ctrl_reg_out, 16'h4000, "second reset");
    $display("test lock done");
    tally_and_finish;
  end
endmodule // test_sic_ctrl
`default_nettype wire
